// File: hw/etu_core.sv
// Event timer unit: filtered inputs, count clock select, compare and outputs
`default_nettype none
module etu_core
    import etu_pkg::*;
#(
    parameter int PINS = etu_pkg::PIN_N
)
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic timer_enable_in,
    input wire logic [PINS-1:0] timer_input_pin_in,
    input wire logic [etu_pkg::FILT_CLK_W-1:0] filter_sampling_clock_select_in,
    input wire logic [etu_pkg::FILT_CNT_W-1:0] filter_sample_count_select_in,
    input wire logic external_event_clock_enable_in,
    input wire logic [2:0] operating_mode_select_in,
    input wire logic [1:0] capture_edge_select_in,
    input wire logic [15:0] compare_capture_reg0_in,
    input wire logic [15:0] compare_capture_reg_k_in,
    output logic [PINS-1:0] filtered_pin_out,
    output logic [15:0] counter_out,
    output logic cc0_match_out,
    output logic cck_match_out,
    output logic timer_output_pin_k_out,
    output logic overflow_out
);
    import etu_pkg::*;

    logic [PINS-1:0] filt;
    logic ev_prev;
    logic count_tick;
    logic ext_mode;
    logic ext_clk;
    logic [15:0] cnt;
    logic running;
    etu_state_t state;
    etu_state_t next_state;
    logic [15:0] next_cnt;
    logic cc0_hit;
    logic cck_hit;
    logic wrap_hit;
    logic ev_rise;
    logic next_tout;

    // ------------------------------------------------------------
    // Input filters
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_filt
            etu_noise_filter u_filt (
                .clock_in(clock_in),
                .srst_in(srst_in),
                .pin_in(timer_input_pin_in[gi]),
                .filter_sampling_clock_select_in(filter_sampling_clock_select_in),
                .filter_sample_count_select_in(filter_sample_count_select_in),
                .filtered_out(filt[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Count clock selection
    // ------------------------------------------------------------
    assign ext_mode = operating_mode_select_in == MODE_EXT_EVENT;
    // Only pin 0 can clock the counter; edge select is software's duty
    assign ext_clk = ext_mode || external_event_clock_enable_in;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            ev_prev <= 1'b0;
        end else begin
            ev_prev <= filt[0];
        end
    end

    // Edge is taken after the filter, so a glitch on the pin never counts
    assign ev_rise = filt[0] && !ev_prev;

    always_comb begin
        if (ext_clk) begin
            count_tick = ev_rise;
        end else begin
            count_tick = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    // Enable is taken one cycle late, so a start always counts from a clean zero;
    // stopping clears the count and the timer output
    always_comb begin
        next_state = state;
        case (state)
            ETU_OFF: begin
                if (timer_enable_in) begin
                    next_state = ETU_RUN;
                end
            end
            ETU_RUN: begin
                if (!timer_enable_in) begin
                    next_state = ETU_OFF;
                end
            end
            default: begin
                next_state = ETU_OFF;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state <= ETU_OFF;
        end else begin
            state <= next_state;
        end
    end

    assign running = state == ETU_RUN;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    assign cc0_hit = count_tick && cnt == compare_capture_reg0_in;
    // Compare k only flags a match; it never restarts the count
    assign cck_hit = count_tick && cnt == compare_capture_reg_k_in;
    // Only exact equality restarts the count: a limit lowered below the count
    // is passed, and the counter runs through ffff and wraps
    assign wrap_hit = count_tick && !cc0_hit && cnt == 16'hffff;

    always_comb begin
        if (cc0_hit) begin
            next_cnt = CNT_RESET;
        end else if (count_tick) begin
            next_cnt = cnt + 16'h0001;
        end else begin
            next_cnt = cnt;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in || !running) begin
            cnt <= CNT_RESET;
        end else begin
            cnt <= next_cnt;
        end
    end

    // ------------------------------------------------------------
    // Match and overflow pulses
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in || !running) begin
            cc0_match_out <= 1'b0;
        end else begin
            cc0_match_out <= cc0_hit;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in || !running) begin
            cck_match_out <= 1'b0;
        end else begin
            cck_match_out <= cck_hit;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in || !running) begin
            overflow_out <= 1'b0;
        end else begin
            overflow_out <= wrap_hit;
        end
    end

    // ------------------------------------------------------------
    // Timer output: toggles on compare 0 match, none in event mode
    // ------------------------------------------------------------
    always_comb begin
        if (ext_mode) begin
            next_tout = 1'b0;
        end else if (cc0_hit) begin
            next_tout = !timer_output_pin_k_out;
        end else begin
            next_tout = timer_output_pin_k_out;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in || !running) begin
            timer_output_pin_k_out <= 1'b0;
        end else begin
            timer_output_pin_k_out <= next_tout;
        end
    end

    // ------------------------------------------------------------
    // Filtered pin outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            filtered_pin_out <= '0;
        end else begin
            filtered_pin_out <= filt;
        end
    end

    assign counter_out = cnt;
endmodule
`default_nettype wire

// File: include/etu_pkg.sv
// Package of constants and types for the event timer unit
`default_nettype none
package etu_pkg;
    localparam int CNT_W = 16;
    localparam int PIN_N = 4;
    localparam int FILT_CLK_W = 3;
    localparam int FILT_CNT_W = 2;
    localparam logic [2:0] MODE_INTERVAL = 3'h0;
    localparam logic [2:0] MODE_EXT_EVENT = 3'h1;
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CMP_RESET = 16'hffff;
    localparam logic [2:0] FILT_CLK_RESET = 3'h0;
    localparam logic [1:0] FILT_CNT_RESET = 2'h0;
    localparam logic [7:0] FILT_PRESC_RESET = 8'h00;
    localparam int FILT_BASE_SAMPLES = 2;
    typedef enum logic [2:0] {ETU_OFF, ETU_RUN} etu_state_t;
endpackage
`default_nettype wire

// File: hw/etu_noise_filter.sv
// Digital noise filter for one timer input pin
`default_nettype none
module etu_noise_filter
    import etu_pkg::*;
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic pin_in,
    input wire logic [etu_pkg::FILT_CLK_W-1:0] filter_sampling_clock_select_in,
    input wire logic [etu_pkg::FILT_CNT_W-1:0] filter_sample_count_select_in,
    output logic filtered_out
);
    import etu_pkg::*;

    logic meta;
    logic sync;
    logic [7:0] presc;
    logic sample_tick;
    logic [3:0] agree;
    logic [3:0] need;

    // Two-stage synchroniser: pin is asynchronous
    always_ff @(posedge clock_in) begin
        meta <= pin_in;
        sync <= meta;
    end

    // Sampling clock is clock_in divided by 2**select
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            presc <= FILT_PRESC_RESET;
        end else begin
            presc <= presc + 8'h01;
        end
    end

    always_comb begin
        if (filter_sampling_clock_select_in == 3'h0) begin
            sample_tick = 1'b1;
        end else begin
            sample_tick = (presc & ((8'h01 << filter_sampling_clock_select_in) - 8'h01))
                == 8'h00;
        end
    end

    assign need = 4'(FILT_BASE_SAMPLES) + {2'h0, filter_sample_count_select_in};

    // Filter is active from reset on, before any setup; default is fastest setting
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            agree <= 4'h0;
            filtered_out <= 1'b0;
        end else if (sample_tick) begin
            if (sync == filtered_out) begin
                agree <= 4'h0;
            end else if (agree + 4'h1 >= need) begin
                agree <= 4'h0;
                filtered_out <= sync;
            end else begin
                agree <= agree + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/etu_core_asserts.sv
// Port assertions for the event timer core
`default_nettype none
module etu_core_asserts
    import etu_pkg::*;
#(parameter int PINS = 4)
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic [PINS-1:0] timer_input_pin_in,
    input wire logic external_event_clock_enable_in,
    input wire logic [2:0] operating_mode_select_in,
    input wire logic [PINS-1:0] filtered_pin_out,
    input wire logic [15:0] counter_out,
    input wire logic cc0_match_out,
    input wire logic timer_output_pin_k_out,
    input wire logic overflow_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // Eight quiet cycles cover sync plus samples at the reset filter setting
    chk_filter_settles: assert property (
        (timer_input_pin_in == $past(timer_input_pin_in))[*8]
        |-> filtered_pin_out == timer_input_pin_in) else $error("filter out of step");
    chk_pin0_clock_only: assert property (
        ((external_event_clock_enable_in || operating_mode_select_in == MODE_EXT_EVENT)
        && $stable(filtered_pin_out[0]))[*4]
        |-> $stable(counter_out)) else $error("count without pin0 edge");
    chk_event_mode_quiet: assert property (
        (operating_mode_select_in == MODE_EXT_EVENT)[*2] |-> !timer_output_pin_k_out)
        else $error("timer output in event mode");
    chk_overflow_wrap: assert property (
        $rose(overflow_out) |-> $past(counter_out) == 16'hffff
        || $past(counter_out, 2) == 16'hffff) else $error("overflow without full count");
    chk_match_restart: assert property (
        cc0_match_out |-> counter_out <= 16'h0001) else $error("match without restart");
    cover property (overflow_out);
    cover property (cc0_match_out && operating_mode_select_in == MODE_EXT_EVENT);
    cover property ($rose(filtered_pin_out[0]));
endmodule
bind etu_core etu_core_asserts #(.PINS(PINS)) chk_u (.clock_in(clock_in), .srst_in(srst_in),
    .timer_input_pin_in(timer_input_pin_in), .operating_mode_select_in(operating_mode_select_in),
    .external_event_clock_enable_in(external_event_clock_enable_in),
    .filtered_pin_out(filtered_pin_out), .counter_out(counter_out),
    .cc0_match_out(cc0_match_out), .timer_output_pin_k_out(timer_output_pin_k_out),
    .overflow_out(overflow_out));
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the event timer core
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import etu_pkg::*;
    logic clock_in, srst_in, en, ext, m0, tout, ovf;
    logic [3:0] pins, filt;
    logic [2:0] mode;
    logic [15:0] ccr0, cnt;
    int error_cnt, tests_run, cycles, n, k;
    // Filter selects and edge select stay at reset values: shortest legal settling
    etu_core dut_u (.clock_in(clock_in), .srst_in(srst_in), .timer_enable_in(en),
        .timer_input_pin_in(pins), .filter_sampling_clock_select_in(3'h0),
        .filter_sample_count_select_in(2'h0), .external_event_clock_enable_in(ext),
        .operating_mode_select_in(mode), .capture_edge_select_in(2'h0),
        .compare_capture_reg0_in(ccr0), .compare_capture_reg_k_in(ccr0),
        .filtered_pin_out(filt), .counter_out(cnt), .cc0_match_out(m0), .cck_match_out(),
        .timer_output_pin_k_out(tout), .overflow_out(ovf));
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    task automatic complete_run();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clock_in);
    endtask
    task automatic pulse(input int i);
        pins[i] <= 1'b1;
        tick(8);
        pins[i] <= 1'b0;
        tick(8);
    endtask
    task automatic wait_match();
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (m0 !== 1'b1 && n < 200);
    endtask
    initial begin
        srst_in = 1'b1;
        en = 1'b0;
        ext = 1'b0;
        pins = 4'h0;
        mode = MODE_INTERVAL;
        ccr0 = 16'h0005;
        tick(16);
        srst_in <= 1'b0;
        tick(2);
        chk("counter", 16'h0000, cnt);
        pins[3] <= 1'b1;
        tick(1);
        pins[3] <= 1'b0;
        tick(10);
        chk("glitch", 16'h0000, {15'h0, filt[3]});
        pulse(3);
        en <= 1'b1;
        wait_match();
        chk("toggle", 16'h0001, {15'h0, tout});
        wait_match();
        chk("period", 16'h0006, n[15:0]);
        chk("toggle back", 16'h0000, {15'h0, tout});
        ccr0 <= 16'h0040;
        for (n = 0; cnt < 16'h0020 && n < 100; n++) tick(1);
        ccr0 <= 16'h0010;
        for (n = 0, k = 0; ovf !== 1'b1 && n < 70000; n++) begin
            tick(1);
            k += (m0 === 1'b1);
        end
        chk("early match", 16'h0000, k[15:0]);
        chk("overflow", 16'h0001, {15'h0, ovf});
        en <= 1'b0;
        mode <= MODE_EXT_EVENT;
        tick(4);
        chk("stopped", 16'h0000, cnt);
        ccr0 <= 16'h0003;
        en <= 1'b1;
        for (int i = 1; i < 4; i++) pulse(i);
        chk("other pins", 16'h0000, cnt);
        repeat (2) pulse(0);
        chk("events", 16'h0002, cnt);
        repeat (2) pulse(0);
        chk("event wrap", 16'h0000, cnt);
        chk("event out", 16'h0000, {15'h0, tout});
        en <= 1'b0;
        mode <= MODE_INTERVAL;
        tick(4);
        chk("idle out", 16'h0000, {15'h0, tout});
        {en, ext} <= 2'h3;
        repeat (4) pulse(0);
        chk("event toggle", 16'h0001, {15'h0, tout});
        complete_run();
    end
endmodule
`default_nettype wire
